// [hw/ctp_pkg.sv]
// Package: register map, field layout and state types of the clock trim block
package ctp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_API_CTL = 10'h2f0;
  localparam logic [9:0] IDX_API_RATE_H = 10'h2f4;
  localparam logic [9:0] IDX_API_RATE_L = 10'h2f5;
  localparam logic [9:0] IDX_TEST_A = 10'h2f6;
  localparam logic [9:0] IDX_TEMP_TRIM = 10'h2f7;
  localparam logic [9:0] IDX_IRC_TRIM_H = 10'h2f8;
  localparam logic [9:0] IDX_IRC_TRIM_L = 10'h2f9;
  localparam logic [9:0] IDX_OSC_CTL = 10'h2fa;
  localparam logic [9:0] IDX_GUARD = 10'h2fb;
  localparam logic [9:0] IDX_TEST_B = 10'h2fc;
  localparam logic [9:0] IDX_OSC_CTL2 = 10'h2fd;
  localparam logic [9:0] IDX_STATUS = 10'h2fe;
  // Field positions
  localparam int API_SRC_BIT = 7;
  localparam int API_EN_BIT = 2;
  localparam int TEMP_OE_BIT = 7;
  localparam int TC_HI_BIT = 15;
  localparam int TC_LO_BIT = 11;
  localparam int FREQ_HI_BIT = 9;
  localparam int COARSE_LO_BIT = 6;
  localparam int OSC_EN_BIT = 7;
  localparam int OSC_LOSS_RESET_EN_BIT = 1;
  localparam int SWING_BIT = 0;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_OSC_BIT = 1;
  localparam int ST_PINS_BIT = 2;
  localparam int ST_GUARD_BIT = 3;
  // Writing this key opens the guard; anything else closes it
  localparam logic [7:0] GUARD_KEY = 8'h26;
  localparam logic [7:0] TEMP_TRIM_MASK = 8'h8f;
  localparam logic [15:0] IRC_TRIM_MASK = 16'hfbff;
  localparam logic [7:0] OSC2_MASK = 8'h03;
  localparam logic [7:0] API_CTL_MASK = 8'h84;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic GUARD_RST = 1'b0;
  // Periodic timer: ACLK periods count four times against the rate, bus clocks twice
  localparam int API_CNT_W = 19;
  localparam real ACLK_TRIM_KHZ = 20.0;
  localparam real API_MAX_MS = 13107.2;

  typedef enum logic [0:0] {ST_LOAD, ST_RUN} ctp_phase_t;

  typedef struct packed {
    logic [7:0] temp_trim;
    logic [15:0] irc_trim;
    logic [7:0] osc_ctl;
    logic [7:0] osc_ctl2;
    logic [7:0] test_a;
    logic [7:0] test_b;
    logic [7:0] api_ctl;
    logic [15:0] api_rate;
  } ctp_cfg_t;

  typedef struct packed {
    logic guard;
    logic lock;
    logic osc_stable;
    logic pins_reserved;
  } ctp_flags_t;

  typedef struct packed {
    ctp_phase_t phase;
    ctp_cfg_t cfg;
    ctp_flags_t flg;
    logic [API_CNT_W-1:0] api_cnt;
    logic api_pulse;
    logic ack;
    logic [31:0] rdata;
  } ctp_state_t;
endpackage

// [hw/ctp_regs.sv]
// Clock trim, oscillator control and write-guard registers on Wishbone
`timescale 1ns/10ps
`default_nettype none
module ctp_regs
  import ctp_pkg::*;
(
  input wire logic SYS_CLK_I, // 40 MHz bus clock
  input wire logic RST_I, // Synchronous reset, active high
  input wire logic CYC_I, // Wishbone cycle
  input wire logic STB_I, // Wishbone strobe
  input wire logic WE_I, // Wishbone write enable
  input wire logic [11:0] ADR_I, // Wishbone byte address
  input wire logic [3:0] SEL_I, // Wishbone byte lanes
  input wire logic [31:0] DAT_I, // Wishbone write data
  output logic [31:0] DAT_O, // Wishbone read data
  output logic ACK_O, // Wishbone acknowledge
  input wire logic SPECIAL_MODE_I, // Device in special mode
  input wire logic PLL_SEL_I, // PLL drives the bus clock
  input wire logic LOCK_IN_TOL_I, // Lock detector within lock tolerance
  input wire logic LOCK_OUT_TOL_I, // Lock detector outside unlock tolerance
  input wire logic OSC_OK_I, // Oscillator qualified stable
  input wire logic OSC_LOST_I, // External oscillation lost
  input wire logic ACLK_TICK_I, // One pulse per RC clock period
  input wire logic FLASH_VALID_I, // Flash trim words valid
  input wire logic [7:0] FLASH_TEMP_I, // Flash temperature trim
  input wire logic [15:0] FLASH_IRC_I, // Flash reference trim pair
  output logic GUARD_O, // Clock configuration guard closed
  output logic CFG_WR_OK_O, // Outside guarded registers may be written
  output logic TEMP_OFS_EN_O, // Temperature offset enabled
  output logic [3:0] TEMP_OFS_O, // Temperature offset code
  output logic [3:0] COARSE_TRIM_O, // Coarse frequency trim
  output logic [5:0] FINE_TRIM_O, // Fine frequency trim
  output logic TC_COMP_EN_O, // Tempco compensation active
  output logic TC_POSITIVE_O, // Tempco variation positive
  output logic [3:0] TC_STEP_O, // Tempco variation magnitude
  output logic REF_EXT_O, // PLL reference from external oscillator
  output logic PINS_RESERVED_O, // Crystal pins held by oscillator
  output logic OSC_FULL_SWING_O, // Oscillator in full swing mode
  output logic OSC_LOSS_RST_O, // Oscillator clock monitor reset request
  output logic LOCK_O, // PLL lock flag
  output logic OSC_STABLE_O, // Oscillator stable flag
  output logic [7:0] TEST_A_O, // Factory test register A
  output logic [7:0] TEST_B_O, // Factory test register B
  output logic TIMEOUT_O, // Periodic time-out, one-cycle pulse
  output logic LOADED_O // Flash trims loaded
);

  ctp_state_t s;
  ctp_state_t next_s;
  logic req;
  logic wr;
  logic [9:0] idx;
  logic [7:0] wb;
  logic irc_ok;
  logic osc_ok;
  logic osc2_ok;
  logic flag_clr;
  logic api_tick;
  logic [API_CNT_W-1:0] api_last;

  // Bus clocks per time-out: 2*(rate+1); RC clocks per time-out: 4*(rate+1), RC counts twice
  function automatic logic [API_CNT_W-1:0] api_limit(
    input logic [15:0] rate,
    input logic bus_src
  );
    logic [API_CNT_W-1:0] n;
    n = {{(API_CNT_W-16){1'b0}}, rate} + {{(API_CNT_W-1){1'b0}}, 1'b1};
    api_limit = bus_src ? (n << 1) : (n << 2);
  endfunction

  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    hit = (a == r);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Bus decode and write qualification

  assign req = CYC_I & STB_I & ~s.ack;
  assign wr = req & WE_I & SEL_I[0];
  assign idx = ADR_I[11:2];
  assign wb = DAT_I[7:0];

  assign irc_ok = ~s.flg.guard;
  assign osc_ok = ~s.flg.guard & PLL_SEL_I;
  assign osc2_ok = osc_ok & ~s.cfg.osc_ctl[OSC_EN_BIT];

  assign flag_clr = wr & ((osc_ok & hit(idx, IDX_OSC_CTL))
    | (irc_ok & PLL_SEL_I
       & (hit(idx, IDX_IRC_TRIM_H) | hit(idx, IDX_IRC_TRIM_L))));

  assign api_tick = s.cfg.api_ctl[API_SRC_BIT] | ACLK_TICK_I;
  assign api_last = api_limit(s.cfg.api_rate, s.cfg.api_ctl[API_SRC_BIT])
    - {{(API_CNT_W-1){1'b0}}, 1'b1};

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    next_s.ack = req;
    next_s.api_pulse = 1'b0;

    if (s.phase == ST_LOAD && FLASH_VALID_I) begin
      next_s.cfg.temp_trim = FLASH_TEMP_I & TEMP_TRIM_MASK;
      next_s.cfg.irc_trim = FLASH_IRC_I & IRC_TRIM_MASK;
      next_s.phase = ST_RUN;
    end

    if (LOCK_IN_TOL_I) begin
      next_s.flg.lock = 1'b1;
    end else if (LOCK_OUT_TOL_I) begin
      next_s.flg.lock = 1'b0;
    end
    // Stable status cannot outlive lock
    if (OSC_OK_I && s.cfg.osc_ctl[OSC_EN_BIT] && next_s.flg.lock) begin
      next_s.flg.osc_stable = 1'b1;
    end else if (!next_s.flg.lock || !s.cfg.osc_ctl[OSC_EN_BIT]) begin
      next_s.flg.osc_stable = 1'b0;
    end
    // Write-triggered clear dominates a same-cycle detector set
    if (flag_clr) begin
      next_s.flg.lock = 1'b0;
      next_s.flg.osc_stable = 1'b0;
    end

    if (wr) begin
      unique case (idx)
        IDX_API_CTL: begin
          next_s.cfg.api_ctl = wb & API_CTL_MASK;
          // Source may only move while the timer is stopped
          if (s.cfg.api_ctl[API_EN_BIT] || wb[API_EN_BIT]) begin
            next_s.cfg.api_ctl[API_SRC_BIT] = s.cfg.api_ctl[API_SRC_BIT];
          end
        end
        IDX_API_RATE_H: begin
          if (!s.cfg.api_ctl[API_EN_BIT]) begin
            next_s.cfg.api_rate[15:8] = wb;
          end
        end
        IDX_API_RATE_L: begin
          if (!s.cfg.api_ctl[API_EN_BIT]) begin
            next_s.cfg.api_rate[7:0] = wb;
          end
        end
        IDX_TEST_A: begin
          if (SPECIAL_MODE_I) begin
            next_s.cfg.test_a = wb;
          end
        end
        IDX_TEST_B: begin
          if (SPECIAL_MODE_I) begin
            next_s.cfg.test_b = wb;
          end
        end
        IDX_TEMP_TRIM: begin
          next_s.cfg.temp_trim = wb & TEMP_TRIM_MASK;
        end
        IDX_IRC_TRIM_H: begin
          if (irc_ok) begin
            next_s.cfg.irc_trim[15:8] = wb & IRC_TRIM_MASK[15:8];
          end
        end
        IDX_IRC_TRIM_L: begin
          if (irc_ok) begin
            next_s.cfg.irc_trim[7:0] = wb;
          end
        end
        IDX_OSC_CTL: begin
          if (osc_ok) begin
            next_s.cfg.osc_ctl = wb;
            if (wb[OSC_EN_BIT]) begin
              next_s.flg.pins_reserved = 1'b1;
            end
          end
        end
        IDX_OSC_CTL2: begin
          if (osc2_ok) begin
            next_s.cfg.osc_ctl2 = wb & OSC2_MASK;
          end
        end
        IDX_GUARD: begin
          next_s.flg.guard = (wb != GUARD_KEY);
        end
        default: begin
        end
      endcase
    end

    if (!s.cfg.api_ctl[API_EN_BIT]) begin
      next_s.api_cnt = '0;
    end else if (api_tick) begin
      if (s.api_cnt >= api_last) begin
        next_s.api_cnt = '0;
        next_s.api_pulse = 1'b1;
      end else begin
        next_s.api_cnt = s.api_cnt + {{(API_CNT_W-1){1'b0}}, 1'b1};
      end
    end

    // Unmapped addresses answer zero without error
    next_s.rdata = '0;
    if (req && !WE_I) begin
      unique case (idx)
        IDX_API_CTL: next_s.rdata[7:0] = s.cfg.api_ctl;
        IDX_API_RATE_H: next_s.rdata[7:0] = s.cfg.api_rate[15:8];
        IDX_API_RATE_L: next_s.rdata[7:0] = s.cfg.api_rate[7:0];
        IDX_TEST_A: next_s.rdata[7:0] = s.cfg.test_a;
        IDX_TEST_B: next_s.rdata[7:0] = s.cfg.test_b;
        IDX_TEMP_TRIM: next_s.rdata[7:0] = s.cfg.temp_trim;
        IDX_IRC_TRIM_H: next_s.rdata[7:0] = s.cfg.irc_trim[15:8];
        IDX_IRC_TRIM_L: next_s.rdata[7:0] = s.cfg.irc_trim[7:0];
        IDX_OSC_CTL: next_s.rdata[7:0] = s.cfg.osc_ctl;
        IDX_OSC_CTL2: next_s.rdata[7:0] = s.cfg.osc_ctl2;
        IDX_GUARD: next_s.rdata[0] = s.flg.guard;
        IDX_STATUS: begin
          next_s.rdata[ST_LOCK_BIT] = s.flg.lock;
          next_s.rdata[ST_OSC_BIT] = s.flg.osc_stable;
          next_s.rdata[ST_PINS_BIT] = s.flg.pins_reserved;
          next_s.rdata[ST_GUARD_BIT] = s.flg.guard;
        end
        default: next_s.rdata = '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      s.phase <= ST_LOAD;
      s.cfg.temp_trim <= RST_BYTE;
      s.cfg.irc_trim <= RST_WORD;
      s.cfg.osc_ctl <= RST_BYTE;
      s.cfg.osc_ctl2 <= RST_BYTE;
      s.cfg.test_a <= RST_BYTE;
      s.cfg.test_b <= RST_BYTE;
      s.cfg.api_ctl <= RST_BYTE;
      s.cfg.api_rate <= RST_WORD;
      s.flg.guard <= GUARD_RST;
      s.flg.lock <= 1'b0;
      s.flg.osc_stable <= 1'b0;
      s.flg.pins_reserved <= 1'b0;
      s.api_cnt <= '0;
      s.api_pulse <= 1'b0;
      s.ack <= 1'b0;
      s.rdata <= '0;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ACK_O = s.ack;
  assign DAT_O = s.rdata;
  assign GUARD_O = s.flg.guard;
  assign CFG_WR_OK_O = ~s.flg.guard;
  assign TEMP_OFS_EN_O = s.cfg.temp_trim[TEMP_OE_BIT];
  assign TEMP_OFS_O = s.cfg.temp_trim[TEMP_OE_BIT]
    ? s.cfg.temp_trim[3:0] : 4'h0;
  assign COARSE_TRIM_O = s.cfg.irc_trim[FREQ_HI_BIT:COARSE_LO_BIT];
  assign FINE_TRIM_O = s.cfg.irc_trim[COARSE_LO_BIT-1:0];
  assign TC_COMP_EN_O = |s.cfg.irc_trim[TC_HI_BIT-1:TC_LO_BIT];
  assign TC_POSITIVE_O = s.cfg.irc_trim[TC_HI_BIT];
  assign TC_STEP_O = s.cfg.irc_trim[TC_HI_BIT-1:TC_LO_BIT];
  assign REF_EXT_O = s.cfg.osc_ctl[OSC_EN_BIT];
  assign PINS_RESERVED_O = s.flg.pins_reserved;
  assign OSC_FULL_SWING_O = s.cfg.osc_ctl2[SWING_BIT];
  assign OSC_LOSS_RST_O = s.cfg.osc_ctl2[OSC_LOSS_RESET_EN_BIT]
    & s.cfg.osc_ctl[OSC_EN_BIT] & OSC_LOST_I;
  assign LOCK_O = s.flg.lock;
  assign OSC_STABLE_O = s.flg.osc_stable;
  assign TEST_A_O = s.cfg.test_a;
  assign TEST_B_O = s.cfg.test_b;
  assign TIMEOUT_O = s.api_pulse;
  assign LOADED_O = (s.phase == ST_RUN);

endmodule
`default_nettype wire

// [testbench/ctp_regs_props.sv]
// Checker: port-level properties of the clock trim register block
`timescale 1ns/10ps
`default_nettype none
module ctp_props
  import ctp_pkg::*;
(
  input wire logic SYS_CLK_I, // Bus clock
  input wire logic RST_I, // Synchronous reset
  input wire logic CYC_I, // Cycle
  input wire logic STB_I, // Strobe
  input wire logic WE_I, // Write enable
  input wire logic [11:0] ADR_I, // Byte address
  input wire logic [3:0] SEL_I, // Byte lanes
  input wire logic [31:0] DAT_I, // Write data
  input wire logic ACK_O, // Acknowledge
  input wire logic PLL_SEL_I, // PLL drives bus clock
  input wire logic GUARD_O, // Guard closed
  input wire logic TEMP_OFS_EN_O, // Offset enabled
  input wire logic [3:0] TEMP_OFS_O, // Offset code
  input wire logic [3:0] COARSE_TRIM_O, // Coarse trim
  input wire logic [5:0] FINE_TRIM_O, // Fine trim
  input wire logic REF_EXT_O, // External reference
  input wire logic PINS_RESERVED_O, // Crystal pins held
  input wire logic LOCK_O, // Lock flag
  input wire logic OSC_STABLE_O, // Oscillator stable flag
  input wire logic LOADED_O // Flash trims loaded
);
  logic wr;
  logic [9:0] idx;
  assign idx = ADR_I[11:2];
  // Only a write taken on this edge counts; ack blocks a retake
  assign wr = CYC_I & STB_I & ~ACK_O & WE_I & SEL_I[0];
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////////////////////////////////////////
  a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not acknowledged");
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("acknowledge longer than one cycle");
  a_guard_open: assert property (wr && idx == IDX_GUARD &&
    DAT_I[7:0] == GUARD_KEY |=> !GUARD_O) else $error("key left guard shut");
  a_guard_close: assert property (wr && idx == IDX_GUARD &&
    DAT_I[7:0] != GUARD_KEY |=> GUARD_O) else $error("guard left open");
  a_trim_locked: assert property (wr && GUARD_O && LOADED_O &&
    (idx == IDX_IRC_TRIM_H || idx == IDX_IRC_TRIM_L)
    |=> $stable({COARSE_TRIM_O, FINE_TRIM_O})) else $error("trim changed");
  a_osc_clear: assert property (wr && idx == IDX_OSC_CTL && !GUARD_O &&
    PLL_SEL_I |=> !LOCK_O && !OSC_STABLE_O) else $error("flags not cleared");
  a_osc_blocked: assert property (wr && idx == IDX_OSC_CTL &&
    (GUARD_O || !PLL_SEL_I) |=> $stable(REF_EXT_O))
    else $error("blocked oscillator write took effect");
  a_pins_sticky: assert property (PINS_RESERVED_O |=> PINS_RESERVED_O)
    else $error("pin reservation dropped");
  a_pins_set: assert property (REF_EXT_O |-> PINS_RESERVED_O)
    else $error("oscillator on without pin reservation");
  a_temp_ofs: assert property (!TEMP_OFS_EN_O |-> TEMP_OFS_O == 4'h0)
    else $error("offset code while offset disabled");
endmodule
bind ctp_regs ctp_props u_ctp_props (.*);
`default_nettype wire

// [testbench/test_ctp_regs.sv]
// Testbench: register, guard, oscillator and timer checks of the trim block
`timescale 1ns/10ps
`default_nettype none
module test_ctp_regs
  import ctp_pkg::*;
;
  logic SYS_CLK_I, RST_I, CYC_I, STB_I, WE_I, SPECIAL_MODE_I, PLL_SEL_I;
  logic LOCK_IN_TOL_I, LOCK_OUT_TOL_I, OSC_OK_I, OSC_LOST_I, ACLK_TICK_I;
  logic FLASH_VALID_I, ACK_O, GUARD_O, CFG_WR_OK_O, TEMP_OFS_EN_O, LOCK_O;
  logic REF_EXT_O, PINS_RESERVED_O, OSC_FULL_SWING_O, OSC_LOSS_RST_O;
  logic OSC_STABLE_O, TC_COMP_EN_O, TC_POSITIVE_O, TIMEOUT_O, LOADED_O;
  logic [11:0] ADR_I;
  logic [3:0] SEL_I, TEMP_OFS_O, COARSE_TRIM_O, TC_STEP_O;
  logic [31:0] DAT_I, DAT_O, rd;
  logic [7:0] FLASH_TEMP_I, TEST_A_O, TEST_B_O;
  logic [15:0] FLASH_IRC_I;
  logic [5:0] FINE_TRIM_O;
  int bad_count = 0;
  int tests_run = 0;

  ctp_regs u_ctp_regs (.*);

  initial begin
    SYS_CLK_I = 1'b0;
    forever #12.5 SYS_CLK_I = ~SYS_CLK_I;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge SYS_CLK_I);
  endtask

  // Classic single cycle; held until ack is sampled, then released
  task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge SYS_CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= {a, 2'b00};
    DAT_I <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge SYS_CLK_I);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    chk(32'(ACK_O), 32'h1);
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask

  task automatic t_flash;
    chk(32'(LOADED_O), 32'h0);
    FLASH_TEMP_I <= 8'h85;
    FLASH_IRC_I <= 16'h9b3c;
    FLASH_VALID_I <= 1'b1;
    idle(3);
    chk(32'(LOADED_O), 32'h1);
    rd_chk(IDX_TEMP_TRIM, 8'h85);
    rd_chk(IDX_IRC_TRIM_H, 8'h9b);
    rd_chk(IDX_IRC_TRIM_L, 8'h3c);
    chk(32'({TEMP_OFS_EN_O, TEMP_OFS_O}), 32'h15);
    chk(32'({COARSE_TRIM_O, FINE_TRIM_O}), 32'h33c);
    chk(32'({TC_COMP_EN_O, TC_POSITIVE_O, TC_STEP_O}), 32'h33);
    wb(1'b1, IDX_TEMP_TRIM, 8'h0a);
    chk(32'({TEMP_OFS_EN_O, TEMP_OFS_O}), 32'h0);
    wb(1'b1, IDX_IRC_TRIM_H, 8'h80);
    chk(32'(TC_COMP_EN_O), 32'h0);
    $display("test flash done");
  endtask

  task automatic t_guard;
    PLL_SEL_I <= 1'b1;
    LOCK_IN_TOL_I <= 1'b1;
    idle(3);
    chk(32'(LOCK_O), 32'h1);
    LOCK_IN_TOL_I <= 1'b0;
    wb(1'b1, IDX_GUARD, 8'h27);
    rd_chk(IDX_GUARD, 8'h01);
    chk(32'(CFG_WR_OK_O), 32'h0);
    wb(1'b1, IDX_IRC_TRIM_L, 8'h11);
    rd_chk(IDX_IRC_TRIM_L, 8'h3c);
    chk(32'(LOCK_O), 32'h1);
    wb(1'b1, IDX_GUARD, GUARD_KEY);
    chk(32'(GUARD_O), 32'h0);
    wb(1'b1, IDX_IRC_TRIM_L, 8'h11);
    rd_chk(IDX_IRC_TRIM_L, 8'h11);
    chk(32'(LOCK_O), 32'h0);
    $display("test guard done");
  endtask

  task automatic t_osc;
    PLL_SEL_I <= 1'b0;
    LOCK_IN_TOL_I <= 1'b1;
    idle(2);
    LOCK_IN_TOL_I <= 1'b0;
    wb(1'b1, IDX_OSC_CTL, 8'h80);
    chk(32'({REF_EXT_O, LOCK_O}), 32'h1);
    PLL_SEL_I <= 1'b1;
    wb(1'b1, IDX_OSC_CTL2, 8'h03);
    chk(32'(OSC_FULL_SWING_O), 32'h1);
    wb(1'b1, IDX_OSC_CTL, 8'h80);
    chk(32'({REF_EXT_O, PINS_RESERVED_O, LOCK_O}), 32'h6);
    // start-up wait
    // No low-power entry is modelled, so the bench only lets time pass
    idle(4);
    OSC_OK_I <= 1'b1;
    LOCK_IN_TOL_I <= 1'b1;
    idle(3);
    rd_chk(IDX_STATUS, 8'h07);
    LOCK_IN_TOL_I <= 1'b0;
    LOCK_OUT_TOL_I <= 1'b1;
    idle(2);
    chk(32'({LOCK_O, OSC_STABLE_O}), 32'h0);
    LOCK_OUT_TOL_I <= 1'b0;
    OSC_OK_I <= 1'b0;
    wb(1'b1, IDX_OSC_CTL2, 8'h00);
    chk(32'(OSC_FULL_SWING_O), 32'h1);
    OSC_LOST_I <= 1'b1;
    idle(2);
    chk(32'(OSC_LOSS_RST_O), 32'h1);
    OSC_LOST_I <= 1'b0;
    wb(1'b1, IDX_OSC_CTL, 8'h00);
    chk(32'({REF_EXT_O, PINS_RESERVED_O}), 32'h1);
    $display("test oscillator done");
  endtask

  task automatic t_test;
    wb(1'b1, IDX_TEST_A, 8'h5a);
    chk(32'(TEST_A_O), 32'h0);
    SPECIAL_MODE_I <= 1'b1;
    wb(1'b1, IDX_TEST_A, 8'h5a);
    wb(1'b1, IDX_TEST_B, 8'ha5);
    chk(32'({TEST_A_O, TEST_B_O}), 32'h5aa5);
    SPECIAL_MODE_I <= 1'b0;
    wb(1'b1, IDX_TEST_B, 8'h00);
    rd_chk(IDX_TEST_B, 8'ha5);
    rd_chk(10'h2f1, 8'h00);
    $display("test factory done");
  endtask

  // Smallest rate and a small one; the full range would take 131072 cycles
  task automatic t_timer;
    int n;
    for (int r = 0; r < 6; r += 5) begin
      wb(1'b1, IDX_API_CTL, 8'h80);
      wb(1'b1, IDX_API_RATE_L, 8'(r));
      wb(1'b1, IDX_API_CTL, 8'h84);
      n = 0;
      while (TIMEOUT_O !== 1'b1 && n < 100) begin
        @(posedge SYS_CLK_I);
        n++;
      end
      n = 0;
      do begin
        @(posedge SYS_CLK_I);
        n++;
      end while (TIMEOUT_O !== 1'b1 && n < 100);
      chk(32'(n), 32'(2 * (r + 1)));
    end
    wb(1'b1, IDX_API_CTL, 8'h80);
    // RC source: a tick every cycle gives four cycles at rate zero
    wb(1'b1, IDX_API_CTL, 8'h00);
    wb(1'b1, IDX_API_RATE_L, 8'h00);
    ACLK_TICK_I <= 1'b1;
    wb(1'b1, IDX_API_CTL, 8'h04);
    n = 0;
    while (TIMEOUT_O !== 1'b1 && n < 100) begin
      @(posedge SYS_CLK_I);
      n++;
    end
    n = 0;
    do begin
      @(posedge SYS_CLK_I);
      n++;
    end while (TIMEOUT_O !== 1'b1 && n < 100);
    chk(32'(n), 32'h4);
    ACLK_TICK_I <= 1'b0;
    wb(1'b1, IDX_API_CTL, 8'h00);
    $display("test timer done");
  endtask

  task automatic t_reset;
    RST_I <= 1'b1;
    idle(5);
    RST_I <= 1'b0;
    idle(1);
    chk(32'({PINS_RESERVED_O, GUARD_O}), 32'h0);
    $display("test reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    bad_count++;
    results();
  end

  initial begin
    {RST_I, CYC_I, STB_I, WE_I, SPECIAL_MODE_I, PLL_SEL_I} = 6'b10_0000;
    {LOCK_IN_TOL_I, LOCK_OUT_TOL_I, OSC_OK_I, OSC_LOST_I} = 4'h0;
    {ACLK_TICK_I, FLASH_VALID_I} = 2'b00;
    ADR_I = 12'h000;
    SEL_I = 4'hf;
    DAT_I = 32'h0000_0000;
    FLASH_TEMP_I = 8'h00;
    FLASH_IRC_I = 16'h0000;
    idle(5);
    RST_I <= 1'b0;
    t_flash();
    t_guard();
    t_osc();
    t_test();
    t_timer();
    t_reset();
    results();
  end
endmodule
`default_nettype wire
